// *** hw/ssp_pkg.sv ***
/*
 * Shared constants and types for the serial slave port with paged register access.
 * Assumes a single 200 MHz core clock and a register image reached one byte at a time.
 */
package ssp_pkg;

	// Register space shape.
	localparam int ADDR_W = 16;
	localparam int USER_SPACE_BIT = 15;
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h58;

	// Page register location and layout.
	localparam logic [15:0] PAGE_OFFSET_2B = 16'hfffc;
	localparam logic [7:0] PAGE_OFFSET_1B = 8'hfc;
	localparam logic [31:0] PAGE_RESET = 32'h0000_0000;
	localparam int PAGE_HI_LSB = 8;

	// Bit and byte counting.
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [1:0] OFF_LEN_1B = 2'h1;
	localparam logic [1:0] OFF_LEN_2B = 2'h2;

	// Timing: clock period, shortest serial clock low time and synchroniser latency.
	localparam int CLK_PERIOD_PS = 5000;
	localparam int SCL_LOW_MIN_NS = 130;
	localparam int SCL_LOW_MIN_CYC = (SCL_LOW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SYNC_STAGES = 2;
	localparam logic [1:0] STRAP_CAPTURE_CYC = 2'h2;

	// Protocol sequencer states, Gray coded along the usual path.
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ADDR_ACK = 3'b011,
		ST_RX = 3'b010,
		ST_RX_ACK = 3'b110,
		ST_TX = 3'b111,
		ST_TX_ACK = 3'b101,
		ST_SKIP = 3'b100
	} ssp_state_e;

	// Loader serial rates.
	typedef enum logic [1:0] {
		SPD_100K = 2'h0,
		SPD_400K = 2'h1,
		SPD_1M = 2'h2
	} ssp_speed_e;

	// Byte request towards the register image.
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ssp_regreq_s;

	// Slave port operating mode.
	typedef struct packed {
		logic i2cMode;
		logic twoByte;
		logic pinAddrEn;
		logic gpioA2En;
	} ssp_portcfg_s;

	// Stored bus address.
	typedef struct packed {
		logic valid;
		logic [6:0] addr;
	} ssp_busaddr_s;

	// Configuration loader options.
	typedef struct packed {
		logic enable;
		logic twoByte;
	} ssp_loadcfg_s;

endpackage

// *** hw/ssp_sync.sv ***
/*
 * Two flip-flop synchroniser for a group of independent levels.
 * Assumes each bit is a slow level; buses whose bits must move together do not belong here.
 */
`timescale 1ns/1ps
module ssp_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst_n,
	// Levels in and out.
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] meta_reg;

	// The first stage feeds only the second, so metastability settles before use.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= RESET_VAL;
			syncOut <= RESET_VAL;
		end else begin
			meta_reg <= asyncIn;
			syncOut <= meta_reg;
		end
	end

endmodule

// *** hw/ssp_serial_slave.sv ***
/*
 * Serial slave port with paged or full-offset register access, plus loader option outputs.
 * Assumes the register image answers a read strobe with data before the next clock edge and
 * that configuration inputs come from logic on core_clk.
 */
`timescale 1ns/1ps
module ssp_serial_slave (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst_n,
	// Serial pins.
	input wire logic sclPin,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic selectOrAddr0Pin,
	input wire logic dinOrAddr1Pin,
	input wire logic addrGpioBit2,
	// Configuration from the register image.
	input wire logic resetSeqDone,
	input wire ssp_pkg::ssp_portcfg_s slavePortConfigField,
	input wire ssp_pkg::ssp_busaddr_s slaveBusAddrField,
	input wire ssp_pkg::ssp_loadcfg_s loaderPortConfigField,
	input wire logic [2:0] eepromRateOk,
	// Register image access.
	output ssp_pkg::ssp_regreq_s regReq,
	input wire logic [7:0] regRdData,
	// Status.
	output logic [31:0] pageSelect,
	output logic portBusy,
	// Loader options.
	output logic loaderBusReq,
	output logic loaderTwoByte,
	output ssp_pkg::ssp_speed_e loaderSpeed
);

	// The shortest low phase must leave room for synchroniser delay plus two cycles for edge detection and decision.
	if (ssp_pkg::SCL_LOW_MIN_CYC < ssp_pkg::SYNC_STAGES + 2) begin : g_rate_check
		$error("Core clock too slow for the fastest serial clock.");
	end

	// Synchronised pin levels.
	logic [4:0] pinSync;
	logic sclS;
	logic sdaS;
	logic addr0S;
	logic addr1S;
	logic gpioS;

	// Edge history and strap capture.
	logic sclPrev_reg;
	logic sdaPrev_reg;
	logic [1:0] capCnt_reg;
	logic a2Cap_reg;

	// Sequencer state.
	ssp_pkg::ssp_state_e state_reg;
	ssp_pkg::ssp_state_e state_next;
	logic [3:0] bitCnt_reg;
	logic [3:0] bitCnt_next;
	logic [7:0] shift_reg;
	logic [7:0] shift_next;
	logic rnw_reg;
	logic rnw_next;
	logic nack_reg;
	logic nack_next;
	logic [1:0] offIdx_reg;
	logic [1:0] offIdx_next;
	logic [15:0] ptr_reg;
	logic [15:0] ptr_next;
	logic [31:0] page_reg;
	logic [31:0] page_next;
	logic twoByte_reg;
	logic twoByte_next;
	logic sdaOe_reg;
	logic sdaOe_next;
	logic rdPend_reg;
	logic rdPend_next;
	ssp_pkg::ssp_regreq_s regReq_reg;
	ssp_pkg::ssp_regreq_s regReq_next;

	// Loader registers.
	logic loaderBusReq_reg;
	logic loaderTwoByte_reg;
	ssp_pkg::ssp_speed_e loaderSpeed_reg;
	ssp_pkg::ssp_speed_e loaderSpeed_next;

	// Pins enter through two flip-flops; idle bus lines rest high.
	ssp_sync #(
		.WIDTH(5),
		.RESET_VAL(5'h1f)
	) pinSyncInst (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.asyncIn({sclPin, sdaIn, selectOrAddr0Pin, dinOrAddr1Pin, addrGpioBit2}),
		.syncOut(pinSync)
	);

	// Shared pin roles in bus mode.
	assign sclS = pinSync[4];
	assign sdaS = pinSync[3];
	assign addr0S = pinSync[2];
	assign addr1S = pinSync[1];
	assign gpioS = pinSync[0];

	// Bus conditions, sampled at the core rate which oversamples even a 1 MHz serial clock.
	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;
	assign sclRise = sclS & ~sclPrev_reg;
	assign sclFall = ~sclS & sclPrev_reg;
	assign startCond = sclS & sclPrev_reg & sdaPrev_reg & ~sdaS;
	assign stopCond = sclS & sclPrev_reg & ~sdaPrev_reg & sdaS;

	// The port only talks once the reset sequence is over and bus mode is chosen.
	logic engaged;
	assign engaged = resetSeqDone & slavePortConfigField.i2cMode;

	// Bus address: stored value or default, optional strap bit 2, optional pin bits 1:0.
	logic [6:0] baseAddr;
	logic [6:0] strapAddr;
	logic [6:0] matchAddr;
	assign baseAddr = slaveBusAddrField.valid ? slaveBusAddrField.addr : ssp_pkg::DEV_ADDR_DEFAULT;
	assign strapAddr = slavePortConfigField.gpioA2En ? {baseAddr[6:3], a2Cap_reg, baseAddr[1:0]} : baseAddr;
	assign matchAddr = slavePortConfigField.pinAddrEn ? {strapAddr[6:2], addr1S, addr0S} : strapAddr;

	// Address decode for the current pointer.
	logic [15:0] effAddr;
	logic pageHit;
	logic userHit;
	logic [15:0] ptrInc;
	logic [1:0] offLen;
	logic [7:0] pageByte;
	logic [7:0] rdByte;
	assign effAddr = twoByte_reg ? ptr_reg : {page_reg[ssp_pkg::PAGE_HI_LSB +: 8], ptr_reg[7:0]};
	assign pageHit = twoByte_reg ? (ptr_reg[15:2] == ssp_pkg::PAGE_OFFSET_2B[15:2])
		: (ptr_reg[7:2] == ssp_pkg::PAGE_OFFSET_1B[7:2]);
	assign userHit = effAddr[ssp_pkg::USER_SPACE_BIT];
	// One-byte bursts stay inside their page; the host must not rely on crossing it.
	assign ptrInc = twoByte_reg ? ptr_reg + 16'h0001 : {ptr_reg[15:8], ptr_reg[7:0] + 8'h01};
	assign offLen = twoByte_reg ? ssp_pkg::OFF_LEN_2B : ssp_pkg::OFF_LEN_1B;
	assign pageByte = page_reg[{ptr_reg[1:0], 3'h0} +: 8];
	// Apart from the page register offsets, the lower half of the space reads as zero and ignores writes.
	assign rdByte = pageHit ? pageByte : (userHit ? regRdData : 8'h00);

	// Loader options are held while the reset sequence runs, then the bus is let go.
	assign loaderSpeed_next = eepromRateOk[2] ? ssp_pkg::SPD_1M
		: (eepromRateOk[1] ? ssp_pkg::SPD_400K : ssp_pkg::SPD_100K);

	// Protocol sequencer.
	always_comb begin
		state_next = state_reg;
		bitCnt_next = bitCnt_reg;
		shift_next = shift_reg;
		rnw_next = rnw_reg;
		nack_next = nack_reg;
		offIdx_next = offIdx_reg;
		ptr_next = ptr_reg;
		page_next = page_reg;
		twoByte_next = twoByte_reg;
		sdaOe_next = sdaOe_reg;
		rdPend_next = 1'b0;
		regReq_next = regReq_reg;
		regReq_next.wr = 1'b0;
		regReq_next.rd = 1'b0;
		// Read data is taken at the end of the strobe cycle and drives the first bit at once.
		if (rdPend_reg) begin
			shift_next = rdByte;
			sdaOe_next = ~rdByte[7];
		end
		if (!engaged) begin
			state_next = ssp_pkg::ST_IDLE;
			sdaOe_next = 1'b0;
		end else if (stopCond) begin
			state_next = ssp_pkg::ST_IDLE;
			sdaOe_next = 1'b0;
		end else if (startCond) begin
			// A repeated start keeps the pointer so a read follows an offset write.
			state_next = ssp_pkg::ST_ADDR;
			bitCnt_next = 4'h0;
			offIdx_next = 2'h0;
			sdaOe_next = 1'b0;
			twoByte_next = slavePortConfigField.twoByte;
		end else begin
			unique case (state_reg)
				ssp_pkg::ST_IDLE, ssp_pkg::ST_SKIP: begin
					sdaOe_next = 1'b0;
				end
				ssp_pkg::ST_ADDR: begin
					if (sclRise) begin
						shift_next = {shift_reg[6:0], sdaS};
						bitCnt_next = bitCnt_reg + 4'h1;
					end else if (sclFall && bitCnt_reg == ssp_pkg::BYTE_BITS) begin
						if (shift_reg[7:1] == matchAddr) begin
							state_next = ssp_pkg::ST_ADDR_ACK;
							sdaOe_next = 1'b1;
							rnw_next = shift_reg[0];
						end else begin
							state_next = ssp_pkg::ST_SKIP;
						end
					end
				end
				ssp_pkg::ST_ADDR_ACK: begin
					if (sclFall) begin
						bitCnt_next = 4'h0;
						sdaOe_next = 1'b0;
						if (rnw_reg) begin
							state_next = ssp_pkg::ST_TX;
							rdPend_next = 1'b1;
							regReq_next.addr = effAddr;
							regReq_next.rd = userHit & ~pageHit;
						end else begin
							state_next = ssp_pkg::ST_RX;
						end
					end
				end
				ssp_pkg::ST_RX: begin
					if (sclRise) begin
						shift_next = {shift_reg[6:0], sdaS};
						bitCnt_next = bitCnt_reg + 4'h1;
					end else if (sclFall && bitCnt_reg == ssp_pkg::BYTE_BITS) begin
						state_next = ssp_pkg::ST_RX_ACK;
						sdaOe_next = 1'b1;
						if (offIdx_reg < offLen) begin
							// Offset bytes arrive high byte first in two-byte mode.
							if (twoByte_reg && offIdx_reg == 2'h0) begin
								ptr_next[15:8] = shift_reg;
							end else begin
								ptr_next[7:0] = shift_reg;
							end
							offIdx_next = offIdx_reg + 2'h1;
						end else begin
							if (pageHit) begin
								page_next[{ptr_reg[1:0], 3'h0} +: 8] = shift_reg;
							end else if (userHit) begin
								regReq_next.addr = effAddr;
								regReq_next.wdata = shift_reg;
								regReq_next.wr = 1'b1;
							end
							ptr_next = ptrInc;
						end
					end
				end
				ssp_pkg::ST_RX_ACK: begin
					if (sclFall) begin
						state_next = ssp_pkg::ST_RX;
						sdaOe_next = 1'b0;
						bitCnt_next = 4'h0;
					end
				end
				ssp_pkg::ST_TX: begin
					if (sclFall) begin
						if (bitCnt_reg == ssp_pkg::BIT_LAST) begin
							state_next = ssp_pkg::ST_TX_ACK;
							sdaOe_next = 1'b0;
							ptr_next = ptrInc;
						end else begin
							shift_next = {shift_reg[6:0], 1'b0};
							sdaOe_next = ~shift_reg[6];
							bitCnt_next = bitCnt_reg + 4'h1;
						end
					end
				end
				ssp_pkg::ST_TX_ACK: begin
					if (sclRise) begin
						nack_next = sdaS;
					end else if (sclFall) begin
						bitCnt_next = 4'h0;
						// A not-acknowledge ends the read; the bus stays released until stop.
						if (nack_reg) begin
							state_next = ssp_pkg::ST_SKIP;
						end else begin
							state_next = ssp_pkg::ST_TX;
							rdPend_next = 1'b1;
							regReq_next.addr = effAddr;
							regReq_next.rd = userHit & ~pageHit;
						end
					end
				end
			endcase
		end
	end

	// Edge history and strap capture a fixed number of cycles after reset release.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclPrev_reg <= 1'b1;
			sdaPrev_reg <= 1'b1;
			capCnt_reg <= 2'h0;
			a2Cap_reg <= 1'b0;
		end else begin
			sclPrev_reg <= sclS;
			sdaPrev_reg <= sdaS;
			if (capCnt_reg != ssp_pkg::STRAP_CAPTURE_CYC) begin
				capCnt_reg <= capCnt_reg + 2'h1;
			end
			if (capCnt_reg == ssp_pkg::STRAP_CAPTURE_CYC - 2'h1) begin
				a2Cap_reg <= gpioS;
			end
		end
	end

	// Sequencer registers.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ssp_pkg::ST_IDLE;
			bitCnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			rnw_reg <= 1'b0;
			nack_reg <= 1'b0;
			offIdx_reg <= 2'h0;
			ptr_reg <= 16'h0000;
			page_reg <= ssp_pkg::PAGE_RESET;
			twoByte_reg <= 1'b0;
			sdaOe_reg <= 1'b0;
			rdPend_reg <= 1'b0;
			regReq_reg <= '0;
		end else begin
			state_reg <= state_next;
			bitCnt_reg <= bitCnt_next;
			shift_reg <= shift_next;
			rnw_reg <= rnw_next;
			nack_reg <= nack_next;
			offIdx_reg <= offIdx_next;
			ptr_reg <= ptr_next;
			page_reg <= page_next;
			twoByte_reg <= twoByte_next;
			sdaOe_reg <= sdaOe_next;
			rdPend_reg <= rdPend_next;
			regReq_reg <= regReq_next;
		end
	end

	// Loader option registers; the request drops as soon as the reset sequence ends.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			loaderBusReq_reg <= 1'b0;
			loaderTwoByte_reg <= 1'b0;
			loaderSpeed_reg <= ssp_pkg::SPD_100K;
		end else begin
			loaderBusReq_reg <= ~resetSeqDone & loaderPortConfigField.enable;
			loaderTwoByte_reg <= loaderPortConfigField.twoByte;
			loaderSpeed_reg <= loaderSpeed_next;
		end
	end

	// Status flop: the port is inside a transaction addressed to it.
	logic portBusy_reg;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			portBusy_reg <= 1'b0;
		end else begin
			portBusy_reg <= (state_next != ssp_pkg::ST_IDLE) && (state_next != ssp_pkg::ST_SKIP)
				&& (state_next != ssp_pkg::ST_ADDR);
		end
	end

	// The data line is open drain: the output level is always low, only the enable moves.
	logic sdaOut_reg;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sdaOut_reg <= 1'b0;
		end else begin
			sdaOut_reg <= 1'b0;
		end
	end

	// Outputs come straight from flops.
	assign sdaOut = sdaOut_reg;
	assign sdaOe = sdaOe_reg;
	assign regReq = regReq_reg;
	assign pageSelect = page_reg;
	assign portBusy = portBusy_reg;
	assign loaderBusReq = loaderBusReq_reg;
	assign loaderTwoByte = loaderTwoByte_reg;
	assign loaderSpeed = loaderSpeed_reg;

endmodule

// *** verif/ssp_serial_slave_asserts.sv ***
/*
 * Concurrent checks on the ports of the serial slave port.
 * Assumes it is bound to ssp_serial_slave and sees nothing but its ports.
 */
`timescale 1ns/1ps
module ssp_serial_slave_asserts (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst_n,
	// Data line and status.
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic [31:0] pageSelect,
	input wire logic portBusy,
	// Configuration.
	input wire logic resetSeqDone,
	input wire ssp_pkg::ssp_portcfg_s slavePortConfigField,
	input wire ssp_pkg::ssp_loadcfg_s loaderPortConfigField,
	input wire logic [2:0] eepromRateOk,
	// Register image and loader options.
	input wire ssp_pkg::ssp_regreq_s regReq,
	input wire logic loaderBusReq,
	input wire logic loaderTwoByte,
	input wire ssp_pkg::ssp_speed_e loaderSpeed
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// Port state: an unready or non-bus port must not hold the line, since it would hang the host.
	not_ready_quiet_a: assert property (
		(!resetSeqDone) [*4] |-> !sdaOe && !portBusy) else $error("Port active while not ready.");
	spi_mode_quiet_a: assert property (
		(!slavePortConfigField.i2cMode) [*4] |-> !sdaOe) else $error("Data line driven outside bus mode.");
	open_drain_a: assert property (
		sdaOut == 1'b0) else $error("Data line driven high.");
	drive_when_busy_a: assert property (
		sdaOe |-> portBusy || $past(portBusy)) else $error("Data line driven outside a matched transfer.");
	page_in_transfer_a: assert property (
		!$stable(pageSelect) |-> $past(portBusy)) else $error("Page register changed outside a transfer.");

	// Register image strobes.
	single_write_a: assert property (
		regReq.wr |-> !regReq.rd ##1 !regReq.wr) else $error("Write strobe not a single pulse.");
	user_half_a: assert property (
		regReq.wr |-> regReq.addr[15]) else $error("Write reached the lower half.");
	page_kept_local_a: assert property (
		regReq.wr |-> regReq.addr[15:2] != 14'h3fff) else $error("Page register write forwarded.");

	// Loader options follow their inputs one cycle later.
	loader_req_a: assert property (
		$past(rst_n) |-> loaderBusReq == ($past(loaderPortConfigField.enable) && !$past(resetSeqDone)))
		else $error("Loader bus request wrong.");
	loader_width_a: assert property (
		$past(rst_n) |-> loaderTwoByte == $past(loaderPortConfigField.twoByte)) else $error("Loader width wrong.");
	loader_rate_a: assert property (
		$past(rst_n) |-> loaderSpeed == ($past(eepromRateOk[2]) ? ssp_pkg::SPD_1M :
		$past(eepromRateOk[1]) ? ssp_pkg::SPD_400K : ssp_pkg::SPD_100K)) else $error("Loader rate wrong.");

	// Main scenarios reached.
	cover property (regReq.wr);
	cover property (regReq.rd);
	cover property ($rose(sdaOe));
endmodule

// *** verif/ssp_host_model.sv ***
/*
 * Bus host model: drives the serial clock and pulls the open-drain data line.
 * Assumes a pull-up on the data line and a caller that steps from 1 ns after a core_clk edge.
 */
`timescale 1ns/1ps
module ssp_host_model (
	// Clock.
	input wire logic core_clk,
	// Device pull on the data line.
	input wire logic sdaOe,
	// Wire levels.
	output logic sclPin,
	output logic sdaWire
);
	logic hostPull = 1'b0;
	int halfCyc = 95;

	initial sclPin = 1'b1;

	// Pull-up: the line is high only when nobody pulls it low.
	assign sdaWire = ~(sdaOe | hostPull);

	task automatic waitCyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// One bit slot; the line changes only well after the clock falls so no false start or stop appears.
	task automatic bitSlot(input logic b, output logic s);
		hostPull = !b;
		waitCyc(halfCyc);
		sclPin = 1'b1;
		waitCyc(halfCyc);
		s = sdaWire;
		sclPin = 1'b0;
		waitCyc(10);
	endtask

	// Start, also used as the repeated start of a read.
	task automatic startCond();
		// The clock is low here for a repeated start and high after a stop, so a short release before raising it is enough.
		hostPull = 1'b0;
		waitCyc(10);
		sclPin = 1'b1;
		waitCyc(halfCyc);
		hostPull = 1'b1;
		waitCyc(halfCyc);
		sclPin = 1'b0;
		waitCyc(10);
	endtask

	task automatic stopCond();
		hostPull = 1'b1;
		waitCyc(halfCyc);
		sclPin = 1'b1;
		waitCyc(halfCyc);
		hostPull = 1'b0;
		waitCyc(10); // The next start adds its own setup time.
	endtask

	task automatic sendByte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitSlot(d[i], s);
		end
		bitSlot(1'b1, s);
		ack = !s;
	endtask

	task automatic recvByte(input logic ackIt, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitSlot(1'b1, s);
			d[i] = s;
		end
		bitSlot(!ackIt, s);
	endtask
endmodule

// *** verif/ssp_serial_slave_tb.sv ***
/*
 * Self-checking bench for the serial slave port: host transfers, address forms, paging, loader options.
 * Assumes the host model and checker files are compiled before it.
 */
`timescale 1ns/1ps
module ssp_serial_slave_tb;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic sclPin;
	logic sdaWire;
	logic sdaOe;
	logic selectOrAddr0Pin = 1'b0;
	logic dinOrAddr1Pin = 1'b0;
	logic addrGpioBit2 = 1'b1;
	logic resetSeqDone = 1'b1;
	ssp_pkg::ssp_portcfg_s portCfg = 4'b1000;
	ssp_pkg::ssp_busaddr_s busAddr = 8'h00;
	ssp_pkg::ssp_loadcfg_s loadCfg = 2'b00;
	logic [2:0] eepromRateOk = 3'h0;
	ssp_pkg::ssp_regreq_s regReq;
	logic [7:0] regRdData = 8'h00;
	logic [31:0] pageSelect;
	logic portBusy;
	int n_mismatch = 0;
	int total_checks = 0;
	logic [23:0] wrLog[$];

	always #2.5 core_clk = ~core_clk;

	ssp_serial_slave i_ssp_serial_slave (.core_clk(core_clk), .rst_n(rst_n), .sclPin(sclPin), .sdaIn(sdaWire),
		.sdaOut(), .sdaOe(sdaOe), .selectOrAddr0Pin(selectOrAddr0Pin), .dinOrAddr1Pin(dinOrAddr1Pin),
		.addrGpioBit2(addrGpioBit2), .resetSeqDone(resetSeqDone), .slavePortConfigField(portCfg),
		.slaveBusAddrField(busAddr), .loaderPortConfigField(loadCfg), .eepromRateOk(eepromRateOk),
		.regReq(regReq), .regRdData(regRdData), .pageSelect(pageSelect), .portBusy(portBusy),
		.loaderBusReq(), .loaderTwoByte(), .loaderSpeed());
	ssp_host_model i_ssp_host_model (.core_clk(core_clk), .sdaOe(sdaOe), .sclPin(sclPin), .sdaWire(sdaWire));

	// Register image stand-in: read data stands within the strobe's own cycle, since the port takes it
	// at the end of that cycle; writes are logged as address and byte.
	always @(posedge regReq.rd) regRdData <= #1 regReq.addr[7:0] ^ 8'h5a;
	always @(posedge core_clk) begin
		if (regReq.wr === 1'b1) wrLog.push_back({regReq.addr, regReq.wdata});
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Whole write burst; all bytes of a register go in one burst.
	task automatic writeSeq(input logic [7:0] q[$], output logic ackAll);
		logic a;
		ackAll = 1'b1;
		wrLog.delete();
		i_ssp_host_model.startCond();
		foreach (q[i]) begin
			i_ssp_host_model.sendByte(q[i], a);
			ackAll &= a;
		end
		i_ssp_host_model.stopCond();
	endtask

	// Offset write, repeated start, then n reads with the last one refused.
	task automatic readSeq(input logic [7:0] offs[$], input int n, output logic [7:0] d[$]);
		logic a;
		logic [7:0] b;
		i_ssp_host_model.startCond();
		i_ssp_host_model.sendByte(8'hb0, a);
		foreach (offs[i]) i_ssp_host_model.sendByte(offs[i], a);
		i_ssp_host_model.startCond();
		i_ssp_host_model.sendByte(8'hb1, a);
		for (int i = 0; i < n; i++) begin
			i_ssp_host_model.recvByte(i < n - 1, b);
			d.push_back(b);
		end
		i_ssp_host_model.stopCond();
	endtask

	task automatic probe(input logic [6:0] dev, input logic expAck);
		logic a;
		writeSeq('{{dev, 1'b0}}, a);
		check(a, expAck);
	endtask

	// Hang guard.
	initial begin
		repeat (110000) @(posedge core_clk);
		n_mismatch++;
		end_sim();
	end

	// Main sequence.
	initial begin
		logic ack;
		logic [7:0] rd[$];
		repeat (20) @(posedge core_clk);
		check(pageSelect, 32'h0);
		check({sdaOe, portBusy, regReq}, 28'h0);
		#1 rst_n = 1'b1;
		i_ssp_host_model.waitCyc(4);
		writeSeq('{8'hb0, 8'hfc, 8'h00, 8'hcb, 8'h10, 8'h20}, ack);
		check(ack, 1'b1);
		check(pageSelect, 32'h2010cb00);
		check(wrLog.size(), 0);
		writeSeq('{8'hb0, 8'he4, 8'h50, 8'h51}, ack);
		check(ack, 1'b1);
		check(wrLog[0], 24'hcbe450);
		check(wrLog[1], 24'hcbe551);
		readSeq('{8'h24}, 2, rd);
		check(rd[0], 8'h24 ^ 8'h5a);
		check(rd[1], 8'h25 ^ 8'h5a);
		rd.delete();
		readSeq('{8'hfc}, 4, rd);
		check({rd[3], rd[2], rd[1], rd[0]}, 32'h2010cb00);
		$display("test paged access done");
		// Address pins change only between transfers.
		selectOrAddr0Pin = 1'b1;
		dinOrAddr1Pin = 1'b1;
		portCfg = 4'b1010;
		probe(7'h5b, 1'b1);
		probe(7'h58, 1'b0);
		portCfg = 4'b1011;
		probe(7'h5f, 1'b1);
		portCfg = 4'b1000;
		busAddr = 8'ha1;
		probe(7'h21, 1'b1);
		probe(7'h58, 1'b0);
		busAddr = 8'h00;
		$display("test bus address done");
		portCfg = 4'b1100;
		// Byte 1 keeps the high address byte that the later one-byte test relies on.
		writeSeq('{8'hb0, 8'hff, 8'hfc, 8'h80, 8'hcb, 8'h00, 8'h00}, ack);
		check(pageSelect, 32'h0000cb80);
		writeSeq('{8'hb0, 8'hcb, 8'he4, 8'h50}, ack);
		check(wrLog[0], 24'hcbe450);
		writeSeq('{8'hb0, 8'h12, 8'h34, 8'h77}, ack);
		check(ack, 1'b1);
		check(wrLog.size(), 0);
		$display("test full offset done");
		portCfg = 4'b1000;
		i_ssp_host_model.halfCyc = 240;
		writeSeq('{8'hb0, 8'h10, 8'h33}, ack);
		check(wrLog[0], 24'hcb1033);
		i_ssp_host_model.halfCyc = 95;
		$display("test slow clock done");
		loadCfg = 2'b11;
		resetSeqDone = 1'b0;
		probe(7'h58, 1'b0);
		check(i_ssp_serial_slave.loaderBusReq, 1'b1);
		check(i_ssp_serial_slave.loaderTwoByte, 1'b1);
		for (int i = 0; i < 8; i++) begin
			eepromRateOk = 3'(i);
			i_ssp_host_model.waitCyc(2);
			check(i_ssp_serial_slave.loaderSpeed, i[2] ? ssp_pkg::SPD_1M : i[1] ? ssp_pkg::SPD_400K : ssp_pkg::SPD_100K);
		end
		resetSeqDone = 1'b1;
		portCfg = 4'b0000;
		probe(7'h58, 1'b0);
		check(i_ssp_serial_slave.loaderBusReq, 1'b0);
		$display("test refusals and loader done");
		end_sim();
	end
endmodule

bind ssp_serial_slave ssp_serial_slave_asserts i_ssp_serial_slave_asserts (.core_clk(core_clk), .rst_n(rst_n),
	.sdaOut(sdaOut), .sdaOe(sdaOe), .pageSelect(pageSelect), .portBusy(portBusy), .resetSeqDone(resetSeqDone),
	.slavePortConfigField(slavePortConfigField), .loaderPortConfigField(loaderPortConfigField),
	.eepromRateOk(eepromRateOk), .regReq(regReq), .loaderBusReq(loaderBusReq), .loaderTwoByte(loaderTwoByte),
	.loaderSpeed(loaderSpeed));
